/* shared/knock_spi_pkg.sv */
// Shared constants and types for the knock processor control port
package knock_spi_pkg;
  localparam int word_bits = 8;
  localparam int cnt_w = 4;
  localparam logic [cnt_w-1:0] last_bit = 4'h7;
  localparam logic [cnt_w-1:0] cnt_rst = 4'h0;
  localparam logic [7:0] word_rst = 8'h00;
  // Command and gain fields of a program word; gain codes from atten_min up attenuate
  localparam int gain_lsb = 0;
  localparam int gain_w = 6;
  localparam logic [1:0] cmd_gain = 2'h1;
  localparam logic [1:0] cmd_knock = 2'h2;
  localparam int cmd_lsb = 6;
  localparam logic [gain_w-1:0] gain_unity = 6'h00;
  localparam logic [gain_w-1:0] atten_min = 6'h01;
  // Integrator restart: 20 us window at the core rate
  localparam int clk_mhz = 250;
  localparam int reset_window_us = 20;
  localparam int reset_window_cyc = reset_window_us * clk_mhz;
  localparam int rw_w = 16;
  localparam int sck_half = 10;
  localparam logic [7:0] half_cnt = 8'(sck_half - 1);
  localparam logic [12:0] integrator_reset_level_mv = 13'h01f4;
  typedef enum logic [1:0] {h_idle, h_low, h_high, h_end} host_state_t;
endpackage

/* shared/knock_spi_if.sv */
// Serial link between host and knock processor
interface knock_spi_if;
  logic sck;
  logic cs_n;
  logic mosi;
  logic miso_o;
  logic miso_oe;
  wire miso = miso_oe ? miso_o : 1'b1;
  modport device(input sck, input cs_n, input mosi, output miso_o, output miso_oe);
  modport host(output sck, output cs_n, output mosi, input miso);
endinterface

/* core/knock_device.sv */
// Knock processor control port: serial receive, mode pins, integrator control
// Summary of operation
// - Talk on link only while select low
// - Output is open drain inverse of input
// - Select high releases the output
// - Every transfer is exactly eight bits
// - Clock idles high, sample rising edge
// - Integrate when pin high, hold when low
// - Test mode when test pin low
// - Core clock from 250MHz oscillator
// - Integration restarts from reset level
// - Attenuated reference forces knock gain unity
// - Integrate rising edge starts new cycle
module knock_device
  import knock_spi_pkg::*;
#(
  parameter int reset_cycles = reset_window_cyc
) (
  input wire logic clk,
  input wire logic nrst,
  knock_spi_if.device link,
  input wire logic int_hold,
  input wire logic test_n,
  output logic [7:0] program_word,
  output logic word_strobe,
  output logic [gain_w-1:0] ref_gain,
  output logic [gain_w-1:0] knock_gain,
  output logic integrating,
  output logic test_mode,
  output logic integrator_reset,
  output logic [12:0] integrator_reset_level
);
  // Command field of a received word compared with one code
  function automatic logic cmd_is(input logic [7:0] w, input logic [1:0] code);
    return w[cmd_lsb +: 2] == code;
  endfunction

  function automatic logic [gain_w-1:0] gain_of(input logic [7:0] w);
    return w[gain_lsb +: gain_w];
  endfunction

  // Link domain, clocked by the serial clock itself
  logic [cnt_w-1:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic [7:0] held_r;
  logic held_tgl_r;
  logic out_r;
  logic oe_r;
  wire logic byte_done = bit_cnt_r == last_bit;
  wire logic [cnt_w-1:0] bit_cnt_nxt = byte_done ? cnt_rst : bit_cnt_r + 4'h1;
  wire logic [7:0] shift_nxt = {shift_r[6:0], link.mosi};

  // Select high clears the count at once, so a cut frame leaves no partial
  // word behind and the next frame counts afresh
  always_ff @(posedge link.sck or posedge link.cs_n) begin
    if (link.cs_n) begin
      bit_cnt_r <= cnt_rst;
    end else begin
      bit_cnt_r <= bit_cnt_nxt;
    end
  end

  // Updated on the sampling edge, where the input has settled; only ever
  // pulls low, the pull-up gives the high level
  always_ff @(posedge link.sck or posedge link.cs_n) begin
    if (link.cs_n) begin
      oe_r <= 1'b0;
      out_r <= 1'b1;
    end else begin
      oe_r <= link.mosi;
      out_r <= 1'b0;
    end
  end

  assign link.miso_o = out_r;
  assign link.miso_oe = oe_r;

  always_ff @(posedge link.sck or negedge nrst) begin
    if (!nrst) begin
      shift_r <= word_rst;
    end else if (!link.cs_n) begin
      shift_r <= shift_nxt;
    end
  end

  // Held word and toggle reset on nrst, not select: a cut frame must never
  // flip the toggle that tells the core a whole word is waiting
  always_ff @(posedge link.sck or negedge nrst) begin
    if (!nrst) begin
      held_r <= word_rst;
      held_tgl_r <= 1'b0;
    end else if (!link.cs_n && byte_done) begin
      held_r <= shift_nxt;
      held_tgl_r <= ~held_tgl_r;
    end
  end

  // Core domain
  logic [2:0] tgl_s_r;
  logic [1:0] cs_s_r;
  logic [1:0] ih_s_r;
  logic [1:0] tm_s_r;
  logic ih_d_r;
  logic pend_r;
  logic [rw_w-1:0] rst_cnt_r;
  wire logic word_in = tgl_s_r[2] ^ tgl_s_r[1];
  wire logic cs_high = cs_s_r[1];
  wire logic ih_level = ih_s_r[1];
  wire logic commit = (pend_r | word_in) & cs_high;
  wire logic pend_nxt = (pend_r | word_in) & ~cs_high;
  wire logic is_gain = cmd_is(held_r, cmd_gain);
  wire logic is_knock = cmd_is(held_r, cmd_knock);
  wire logic [gain_w-1:0] new_gain = gain_of(held_r);
  wire logic attenuates = new_gain >= atten_min;
  wire logic ih_rise = ih_level & ~ih_d_r;
  wire logic cnt_running = rst_cnt_r != '0;
  wire logic cnt_last = rst_cnt_r == rw_w'(1);
  wire logic [rw_w-1:0] rst_cnt_dec = cnt_running ? rst_cnt_r - rw_w'(1) : rst_cnt_r;
  wire logic [rw_w-1:0] rst_cnt_nxt = ih_rise ? rw_w'(reset_cycles) : rst_cnt_dec;

  // Word toggle and select; the toggle has a third flop for its edge
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tgl_s_r <= 3'h0;
      cs_s_r <= 2'h3;
    end else begin
      tgl_s_r <= {tgl_s_r[1:0], held_tgl_r};
      cs_s_r <= {cs_s_r[0], link.cs_n};
    end
  end

  // Mode pins; resets match their idle levels so no false edge follows reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ih_s_r <= 2'h0;
      tm_s_r <= 2'h3;
      ih_d_r <= 1'b0;
    end else begin
      ih_s_r <= {ih_s_r[0], int_hold};
      tm_s_r <= {tm_s_r[0], test_n};
      ih_d_r <= ih_level;
    end
  end

  // A word seen while select is still low waits here until the frame ends
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pend_r <= 1'b0;
      word_strobe <= 1'b0;
      program_word <= word_rst;
    end else begin
      pend_r <= pend_nxt;
      word_strobe <= commit;
      if (commit) begin
        program_word <= held_r;
      end
    end
  end

  // An attenuating reference word puts the knock side back to unity, so the
  // host never needs a second word to keep the pair balanced
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ref_gain <= gain_unity;
      knock_gain <= gain_unity;
    end else if (commit) begin
      if (is_gain) begin
        ref_gain <= new_gain;
      end
      if (is_gain && attenuates) begin
        knock_gain <= gain_unity;
      end else if (is_knock) begin
        knock_gain <= new_gain;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      integrating <= 1'b0;
      test_mode <= 1'b0;
    end else begin
      integrating <= ih_level;
      test_mode <= ~tm_s_r[1];
    end
  end

  // Restart window counts core cycles; a new rising edge reloads it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_cnt_r <= '0;
      integrator_reset <= 1'b0;
    end else begin
      rst_cnt_r <= rst_cnt_nxt;
      integrator_reset <= ih_rise | (cnt_running & ~cnt_last);
    end
  end

  // Restart level in mV, held as a constant for the analog side
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      integrator_reset_level <= integrator_reset_level_mv;
    end else begin
      integrator_reset_level <= integrator_reset_level_mv;
    end
  end
endmodule

/* core/knock_host.sv */
// Host end: sends one eight-bit program word per request
module knock_host
  import knock_spi_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  knock_spi_if.host link,
  input wire logic send,
  input wire logic [7:0] send_word,
  output logic busy,
  output logic [7:0] echo_word,
  output logic done
);
  host_state_t st_r;
  logic [7:0] div_r;
  logic [cnt_w-1:0] bits_r;
  logic [7:0] sh_r;
  logic sck_r;
  logic cs_r;
  logic [1:0] mi_s_r;
  wire logic tick = div_r == 8'h00;
  wire logic last = bits_r == last_bit;
  assign link.sck = sck_r;
  assign link.cs_n = cs_r;
  assign link.mosi = sh_r[7];
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= h_idle;
      div_r <= 8'h00;
      bits_r <= cnt_rst;
      sh_r <= word_rst;
      sck_r <= 1'b1;
      cs_r <= 1'b1;
      mi_s_r <= 2'h3;
      busy <= 1'b0;
      done <= 1'b0;
      echo_word <= word_rst;
    end else begin
      mi_s_r <= {mi_s_r[0], link.miso};
      div_r <= tick ? half_cnt : div_r - 8'h01;
      done <= 1'b0;
      case (st_r)
        h_idle: begin
          sck_r <= 1'b1;
          if (send) begin
            sh_r <= send_word;
            cs_r <= 1'b0;
            busy <= 1'b1;
            bits_r <= cnt_rst;
            div_r <= half_cnt;
            st_r <= h_high;
          end
        end
        h_high: if (tick) begin
          sck_r <= 1'b0;
          // Data moves on the falling edge, half a period clear of sampling
          if (bits_r != cnt_rst) begin
            sh_r <= {sh_r[6:0], 1'b0};
            echo_word <= {echo_word[6:0], ~mi_s_r[1]};
          end
          st_r <= h_low;
        end
        h_low: if (tick) begin
          sck_r <= 1'b1;
          st_r <= last ? h_end : h_high;
          bits_r <= bits_r + 4'h1;
        end
        h_end: if (tick) begin
          echo_word <= {echo_word[6:0], ~mi_s_r[1]};
          cs_r <= 1'b1;
          busy <= 1'b0;
          done <= 1'b1;
          st_r <= h_idle;
        end
        default: st_r <= h_idle;
      endcase
    end
  end
endmodule

/* sim/knock_link_chk.sv */
// Serial link assertions for the knock control port
module knock_link_chk (
  input wire logic clk,
  input wire logic nrst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso_o,
  input wire logic miso_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic sck_r;
  logic [3:0] rise_r;
  // Rising clock edges seen within the current frame
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sck_r <= 1'b1;
      rise_r <= 4'h0;
    end else begin
      sck_r <= sck;
      rise_r <= cs_n ? 4'h0 : rise_r + 4'(sck & ~sck_r);
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence held_low;
    !cs_n [*8];
  endsequence
  chk_release_idle: assert property (cs_n [*3] |-> !miso_oe) else $error("miso not released");
  chk_drive_low: assert property (miso_oe |-> !miso_o) else $error("miso driven high");
  chk_invert_data: assert property ($rose(sck) && !cs_n |-> ##[0:4] miso_oe == mosi)
    else $error("miso not inverse");
  chk_clock_idle: assert property (cs_n |-> sck) else $error("clock low while idle");
  chk_data_steady: assert property ($rose(sck) |-> $stable(mosi)) else $error("mosi moved at edge");
  chk_frame_clock: assert property ($fell(sck) |-> !cs_n) else $error("clock outside frame");
  chk_eight_bits: assert property ($rose(cs_n) |-> rise_r == 4'h8) else $error("frame not 8 bits");
  chk_frame_open: assert property ($fell(cs_n) |-> held_low) else $error("frame too short");
endmodule

/* sim/sensor_dsp_spi_control_port_bench.sv */
// Bench: host and device ends joined over the serial link
module sensor_dsp_spi_control_port_bench import knock_spi_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, nrst, send, int_hold, test_n, busy, done, word_strobe, integrating, test_mode, integrator_reset;
  logic [7:0] send_word, echo_word, program_word;
  logic [5:0] ref_gain, knock_gain;
  logic [12:0] integrator_reset_level;
  logic [7:0] words[4] = '{8'ha5, 8'hff, 8'h01, 8'h80};
  int miscompares = 0;
  int comparisons = 0;
  knock_spi_if link();
  knock_host u_knock_host(.clk, .nrst, .link, .send, .send_word, .busy, .echo_word, .done);
  knock_device #(.reset_cycles(20)) u_knock_device(.clk, .nrst, .link, .int_hold, .test_n, .program_word,
    .word_strobe, .ref_gain, .knock_gain, .integrating, .test_mode, .integrator_reset, .integrator_reset_level);
  knock_link_chk u_knock_link_chk(.clk(clk), .nrst(nrst), .sck(link.sck), .cs_n(link.cs_n), .mosi(link.mosi),
    .miso_o(link.miso_o), .miso_oe(link.miso_oe));
  task automatic check(input string nm, input logic [12:0] got, input logic [12:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic xfer(input logic [7:0] w);
    logic [7:0] old;
    int n;
    old = program_word;
    send = 1'b1;
    send_word = w;
    @(negedge clk) send = 1'b0;
    // Eighth bit is in but select is still low: the word must not be taken yet
    repeat (165) @(negedge clk);
    check("busy", busy, 1'b1);
    check("word mid frame", program_word, old);
    n = 0;
    while (done !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    check("done", done, 1'b1);
    check("idle", busy, 1'b0);
    check("echo", echo_word, w);
    n = 0;
    while (word_strobe !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    check("strobe", word_strobe, 1'b1);
    check("word", program_word, w);
    repeat (6) @(negedge clk);
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #30000;
    miscompares++;
    summarize();
  end
  initial begin
    int n;
    nrst = 1'b0;
    send = 1'b0;
    send_word = 8'h00;
    int_hold = 1'b0;
    test_n = 1'b1;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    check("reset level", integrator_reset_level, integrator_reset_level_mv);
    foreach (words[i]) xfer(words[i]);
    xfer(8'h83);
    check("knock gain set", knock_gain, 6'h03);
    // Nonzero reference gain attenuates, so knock side must fall to unity
    xfer(8'h45);
    check("ref gain", ref_gain, 6'h05);
    check("knock gain", knock_gain, gain_unity);
    $display("words test end");
    int_hold = 1'b1;
    n = 0;
    while (integrator_reset !== 1'b1 && n < 10) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    while (integrator_reset === 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    check("reset cycles", 13'(n), 13'h014);
    check("integrating", integrating, 1'b1);
    int_hold = 1'b0;
    repeat (4) @(negedge clk);
    check("holding", integrating, 1'b0);
    $display("integrator test end");
    test_n = 1'b0;
    repeat (4) @(negedge clk);
    check("test on", test_mode, 1'b1);
    test_n = 1'b1;
    repeat (4) @(negedge clk);
    check("test off", test_mode, 1'b0);
    $display("mode test end");
    summarize();
  end
endmodule
